// ---- rtl/hbfp_consts.svh ----
// Timing counts and field constants for the H-bridge fault protection block.
`ifndef HBFP_CONSTS_SVH
`define HBFP_CONSTS_SVH
`define HBFP_CLK_MHZ 50
`define HBFP_OVP_CYCLES 3'h4
`define HBFP_OCP1_CYCLES 2'h2
`define HBFP_DEGLITCH_NS 150
`define HBFP_DEGLITCH_CNT ((`HBFP_DEGLITCH_NS * `HBFP_CLK_MHZ + 999) / 1000)
`define HBFP_RESTART_US 1000
`define HBFP_RESTART_CNT (`HBFP_RESTART_US * `HBFP_CLK_MHZ)
`endif

// ---- rtl/hbfp_pkg.sv ----
// Types shared by the H-bridge fault protection block.
package hbfp_pkg;
  // Comparator inputs sampled from the analog side.
  typedef struct packed {
    logic overvoltage;
    logic over_temp;
    logic release_temp;
    logic ocp_level1;
    logic ocp_level2;
  } hbfp_trip_t;
  // Fault supervisor states.
  typedef enum logic [1:0] {HBFP_RUN, HBFP_RESTART, HBFP_LATCHED} hbfp_state_t;
endpackage : hbfp_pkg

// ---- rtl/hbfp_top.sv ----
// Fault supervision for the H-bridge: latch, thermal stop, restart and fault pin.
// Behaviour
// - Four consecutive over-voltage cycles latch switching off.
// - Thermal trip stops switching at once.
// - Thermal stop self-releases below the lower point.
// - Fault pin released when clean, low on fault.
// - Latch cleared by reset or enable toggle.
// - Two level-one over-current cycles stop, restart later.
// - Level-two over-current latches off immediately.
// - Enable pulses shorter than deglitch are ignored.
`timescale 1ns/1ps
`include "hbfp_consts.svh"
module hbfp_top #(
  parameter int RESTART_CNT = `HBFP_RESTART_CNT,
  parameter int DEGLITCH_CNT = `HBFP_DEGLITCH_CNT
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic enable_pin,
  input wire logic cycle_tick,
  input wire hbfp_pkg::hbfp_trip_t trip_pin,
  output logic switch_enable,
  output logic fault_flag_n_out,
  output logic fault_flag_n_oe,
  output logic latched_fault
);
  import hbfp_pkg::*;

  // Synchroniser stages; the first stage feeds only the second.
  logic [1:0] en_sync;
  hbfp_trip_t trip_s1;
  hbfp_trip_t trip;
  logic tick_s1;
  logic tick_s2;
  logic tick_d;
  // Deglitched enable and its filter counter.
  logic en_q;
  logic [7:0] dg_cnt;
  logic [7:0] next_dg_cnt;
  logic next_en_q;
  // Supervisor state, counters and thermal hold.
  hbfp_state_t state;
  hbfp_state_t next_state;
  logic [2:0] ov_cnt;
  logic [2:0] next_ov_cnt;
  logic [1:0] oc_cnt;
  logic [1:0] next_oc_cnt;
  logic [31:0] rs_cnt;
  logic [31:0] next_rs_cnt;
  logic therm_stop;
  logic next_therm_stop;
  logic cycle_end;

  // Two-flop synchronisers for every asynchronous input.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      en_sync <= 2'h0;
      trip_s1 <= '0;
      trip <= '0;
      tick_s1 <= 1'b0;
      tick_s2 <= 1'b0;
      tick_d <= 1'b0;
    end
    else
    begin
      en_sync <= {en_sync[0], enable_pin};
      trip_s1 <= trip_pin;
      trip <= trip_s1;
      tick_s1 <= cycle_tick;
      tick_s2 <= tick_s1;
      tick_d <= tick_s2;
    end
  end

  // The rising edge of the switching clock marks the end of a cycle.
  assign cycle_end = tick_s2 & ~tick_d;

  // Enable filter: a new level must persist for the deglitch time to be taken.
  always_comb
  begin
    next_en_q = en_q;
    next_dg_cnt = 8'h00;
    if (en_sync[1] != en_q)
    begin
      if (dg_cnt >= 8'(DEGLITCH_CNT - 1))
      begin
        next_en_q = en_sync[1];
      end
      else
      begin
        next_dg_cnt = dg_cnt + 8'h01;
      end
    end
  end

  // Supervisor next state. Latch-off outranks restart and thermal stop.
  always_comb
  begin
    next_state = state;
    next_ov_cnt = ov_cnt;
    next_oc_cnt = oc_cnt;
    next_rs_cnt = rs_cnt;
    next_therm_stop = therm_stop;
    // Thermal stop has hysteresis: set above trip, cleared only below release.
    if (trip.over_temp)
    begin
      next_therm_stop = 1'b1;
    end
    else if (trip.release_temp)
    begin
      next_therm_stop = 1'b0;
    end
    // Per-cycle run counters.
    if (cycle_end)
    begin
      if (trip.overvoltage)
      begin
        next_ov_cnt = (ov_cnt == `HBFP_OVP_CYCLES) ? ov_cnt : ov_cnt + 3'h1;
      end
      else
      begin
        next_ov_cnt = 3'h0;
      end
      if (trip.ocp_level1)
      begin
        next_oc_cnt = (oc_cnt == `HBFP_OCP1_CYCLES) ? oc_cnt : oc_cnt + 2'h1;
      end
      else
      begin
        next_oc_cnt = 2'h0;
      end
    end
    case (state)
      HBFP_RUN:
      begin
        if (next_ov_cnt == `HBFP_OVP_CYCLES || trip.ocp_level2)
        begin
          next_state = HBFP_LATCHED;
        end
        else if (next_oc_cnt == `HBFP_OCP1_CYCLES)
        begin
          next_state = HBFP_RESTART;
          next_rs_cnt = 32'h0;
          next_oc_cnt = 2'h0;
        end
      end
      HBFP_RESTART:
      begin
        // Over-voltage and over-current counters are held at zero while waiting to restart.
        next_ov_cnt = 3'h0;
        next_oc_cnt = 2'h0;
        if (trip.ocp_level2)
        begin
          next_state = HBFP_LATCHED;
        end
        else if (rs_cnt >= 32'(RESTART_CNT - 1))
        begin
          next_state = HBFP_RUN;
        end
        else
        begin
          next_rs_cnt = rs_cnt + 32'h1;
        end
      end
      HBFP_LATCHED:
      begin
        next_ov_cnt = 3'h0;
        next_oc_cnt = 2'h0;
      end
      default:
      begin
        next_state = HBFP_LATCHED;
      end
    endcase
    // Disabled device: state and counters idle, thermal stop still tracks; the low phase clears the latch.
    if (!en_q)
    begin
      next_state = HBFP_RUN;
      next_ov_cnt = 3'h0;
      next_oc_cnt = 2'h0;
      next_rs_cnt = 32'h0;
    end
  end

  // Register all supervisor state and the registered outputs.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      en_q <= 1'b0;
      dg_cnt <= 8'h00;
      state <= HBFP_RUN;
      ov_cnt <= 3'h0;
      oc_cnt <= 2'h0;
      rs_cnt <= 32'h0;
      therm_stop <= 1'b0;
      switch_enable <= 1'b0;
      fault_flag_n_out <= 1'b0;
      fault_flag_n_oe <= 1'b0;
      latched_fault <= 1'b0;
    end
    else
    begin
      en_q <= next_en_q;
      dg_cnt <= next_dg_cnt;
      state <= next_state;
      ov_cnt <= next_ov_cnt;
      oc_cnt <= next_oc_cnt;
      rs_cnt <= next_rs_cnt;
      therm_stop <= next_therm_stop;
      // Switching stops in the same cycle the trip is seen.
      switch_enable <= next_en_q && next_state == HBFP_RUN && !next_therm_stop;
      fault_flag_n_out <= 1'b0;
      // Pin is only ever pulled low; released means enable low.
      fault_flag_n_oe <= next_state != HBFP_RUN || next_therm_stop;
      latched_fault <= next_state == HBFP_LATCHED;
    end
  end

  // Over-voltage on four cycles in a row must latch.
  a_ovp_latch: assert property (@(posedge clock) disable iff (reset)
    (en_q && next_en_q && state == HBFP_RUN && cycle_end && trip.overvoltage
     && ov_cnt == 3'h3) |=> latched_fault && !switch_enable)
    else $error("over-voltage run did not latch");
  a_ovp_clear: assert property (@(posedge clock) disable iff (reset)
    (cycle_end && !trip.overvoltage) |=> ov_cnt == 3'h0)
    else $error("clean cycle did not clear count");
  a_therm_stop: assert property (@(posedge clock) disable iff (reset)
    trip.over_temp |=> !switch_enable && !fault_flag_n_oe == 1'b0)
    else $error("thermal trip did not stop switching");
  a_therm_hold: assert property (@(posedge clock) disable iff (reset)
    (therm_stop && !trip.release_temp && !trip.over_temp) |=> therm_stop)
    else $error("thermal stop released early");
  a_therm_free: assert property (@(posedge clock) disable iff (reset)
    (therm_stop && trip.release_temp && !trip.over_temp) |=> !therm_stop)
    else $error("thermal stop did not release");
  a_fault_pin: assert property (@(posedge clock) disable iff (reset)
    latched_fault |-> fault_flag_n_oe && !fault_flag_n_out)
    else $error("fault pin not low on latch");
  a_latch_hold: assert property (@(posedge clock) disable iff (reset)
    (latched_fault && en_q && next_en_q) |=> latched_fault)
    else $error("latch cleared without enable toggle");
  // A level-two trip may turn the wait into a latch, so only a return to run counts as early.
  a_restart_wait: assert property (@(posedge clock) disable iff (reset)
    ($rose(state == HBFP_RESTART) && RESTART_CNT > 8) |-> (state != HBFP_RUN || !en_q)[*8])
    else $error("restart too short");
  a_ocp2_latch: assert property (@(posedge clock) disable iff (reset)
    (en_q && next_en_q && trip.ocp_level2) |=> latched_fault)
    else $error("level-two over-current did not latch");
  a_en_glitch: assert property (@(posedge clock) disable iff (reset)
    (en_sync[1] != en_q && dg_cnt == 8'h00 && DEGLITCH_CNT > 1) |=> en_q == $past(en_q))
    else $error("enable took a glitch");
  c_ovp_latch: cover property (@(posedge clock) disable iff (reset) $rose(latched_fault));
  c_restart: cover property (@(posedge clock) disable iff (reset)
    state == HBFP_RESTART ##1 state == HBFP_RUN);
  c_therm: cover property (@(posedge clock) disable iff (reset) $fell(therm_stop));
  c_toggle: cover property (@(posedge clock) disable iff (reset) $fell(latched_fault));
endmodule : hbfp_top

// ---- bench/hbfp_ctrl_model.sv ----
// Model of the system controller that drives the enable pin.
`timescale 1ns/1ps
module hbfp_ctrl_model (
  input wire logic clock,
  output logic enable_pin
);
  // The controller powers up with the block shut down.
  initial enable_pin = 1'h0;
  // Drive a level, then hold it for the given number of cycles.
  task automatic drive(input logic lvl, input int hold);
    enable_pin = lvl;
    repeat (hold) @(posedge clock);
    #2;
  endtask : drive
endmodule : hbfp_ctrl_model

// ---- bench/tb_top.sv ----
// Self-checking bench for the H-bridge fault protection block.
`timescale 1ns/1ps
module tb_top;
  import hbfp_pkg::*;
  // A short restart keeps the over-current wait cheap.
  localparam int RST_CNT = 20;
  logic clock = 1'h0;
  logic reset = 1'h1;
  logic cycle_tick = 1'h0;
  hbfp_trip_t trip_pin = '0;
  logic enable_pin;
  logic switch_enable;
  logic fault_flag_n_out;
  logic fault_flag_n_oe;
  logic latched_fault;
  int miscompares = 0;
  int checks = 0;
  int run = 0;
  logic ov;
  // The open-drain pin sits on a pull-up when released.
  wire fault_wire = fault_flag_n_oe ? fault_flag_n_out : 1'h1;
  always #10 clock = ~clock;
  hbfp_ctrl_model hbfp_ctrl_model_i (.clock(clock), .enable_pin(enable_pin));
  hbfp_top #(.RESTART_CNT(RST_CNT)) hbfp_top_i (
    .clock(clock),
    .reset(reset),
    .enable_pin(enable_pin),
    .cycle_tick(cycle_tick),
    .trip_pin(trip_pin),
    .switch_enable(switch_enable),
    .fault_flag_n_out(fault_flag_n_out),
    .fault_flag_n_oe(fault_flag_n_oe),
    .latched_fault(latched_fault)
  );
  // Expected {switch, fault pin, latch} for a stop and a latch state.
  function automatic logic [2:0] exp_of(input logic stop, input logic latch);
    return {~stop, ~stop, latch};
  endfunction : exp_of
  // Only an unbroken run of four over-voltage cycles latches.
  function automatic logic ovp_latch(input int n);
    return n >= 4;
  endfunction : ovp_latch
  // Wait some edges, then step just past the edge.
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : wt
  // Compare the outputs with the expected triple.
  task automatic chk(input logic [2:0] want);
    checks++;
    if ({switch_enable, fault_wire, latched_fault} !== want)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time,
        {switch_enable, fault_wire, latched_fault}, want);
    end
  endtask : chk
  // One switching cycle with the given trip levels held across it.
  task automatic tick(input logic o, input logic c);
    trip_pin.overvoltage = o;
    trip_pin.ocp_level1 = c;
    wt(4);
    cycle_tick = 1'h1;
    wt(4);
    cycle_tick = 1'h0;
    wt(6);
  endtask : tick
  // Toggle enable low then high to release a latched stop.
  task automatic unlatch();
    trip_pin = '0;
    hbfp_ctrl_model_i.drive(1'h0, 20);
    chk(3'h2);
    hbfp_ctrl_model_i.drive(1'h1, 520);
    chk(exp_of(1'h0, 1'h0));
  endtask : unlatch
  // Print the verdict and stop.
  task automatic complete_run();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // A hang is cut short well past the expected run length.
  initial
  begin
    #400000;
    miscompares++;
    complete_run();
  end
  // Main sequence of scenarios.
  initial
  begin
    void'($urandom(27480));
    wt(20);
    reset = 1'h0;
    hbfp_ctrl_model_i.drive(1'h1, 520);
    chk(exp_of(1'h0, 1'h0));
    // A broken run first, then random over-voltage cycles.
    for (int i = 0; i < 28; i++)
    begin
      ov = (i < 8) ? (i != 3) : 1'($urandom_range(1, 0));
      tick(ov, 1'h0);
      run = ov ? run + 1 : 0;
      chk(exp_of(ovp_latch(run), ovp_latch(run)));
      if (ovp_latch(run))
      begin
        unlatch();
        run = 0;
      end
    end
    // Thermal stop needs the release point, not just a cleared trip.
    trip_pin.over_temp = 1'h1;
    wt(5);
    chk(exp_of(1'h1, 1'h0));
    trip_pin.over_temp = 1'h0;
    wt(5);
    chk(exp_of(1'h1, 1'h0));
    trip_pin.release_temp = 1'h1;
    wt(5);
    chk(exp_of(1'h0, 1'h0));
    trip_pin.release_temp = 1'h0;
    // Level-two over-current latches without any cycle count.
    trip_pin.ocp_level2 = 1'h1;
    wt(5);
    chk(exp_of(1'h1, 1'h1));
    unlatch();
    // Level-one over-current stops after two cycles, then restarts.
    tick(1'h0, 1'h1);
    chk(exp_of(1'h0, 1'h0));
    tick(1'h0, 1'h1);
    chk(exp_of(1'h1, 1'h0));
    trip_pin = '0;
    wt(RST_CNT + 10);
    chk(exp_of(1'h0, 1'h0));
    // Power-on reset also clears a latched stop; enable stays high throughout.
    trip_pin.ocp_level2 = 1'h1;
    wt(5);
    chk(exp_of(1'h1, 1'h1));
    reset = 1'h1;
    trip_pin = '0;
    wt(3);
    chk(3'h2);
    reset = 1'h0;
    wt(20);
    chk(exp_of(1'h0, 1'h0));
    // A short low glitch on enable must be ignored, also while it is still low.
    hbfp_ctrl_model_i.drive(1'h0, 3);
    chk(exp_of(1'h0, 1'h0));
    hbfp_ctrl_model_i.drive(1'h1, 15);
    chk(exp_of(1'h0, 1'h0));
    complete_run();
  end
endmodule : tb_top
